// ### logic/uart_chan_pkg.sv
// Package for one serial channel with FIFOs and DMA ready pins.
// Assumes an 8-bit host bus addressed by a 3-bit register select.
package uart_chan_pkg;
   // Register selects on the 3-bit address
   localparam logic [2:0] ADDR_HOLDING   = 3'h0;
   localparam logic [2:0] ADDR_MASK      = 3'h1;
   localparam logic [2:0] ADDR_QUEUE     = 3'h2;
   localparam logic [2:0] ADDR_LINE_CTL  = 3'h3;
   localparam logic [2:0] ADDR_LINE_STAT = 3'h5;
   // Mask register fields
   localparam int MASK_RX_BIT  = 0;
   localparam int MASK_TX_BIT  = 1;
   localparam int MASK_LS_BIT  = 2;
   localparam int MASK_MS_BIT  = 3;
   localparam int MASK_PWR_BIT = 5;
   localparam logic [7:0] MASK_USED = 8'h0f;
   // Queue control fields
   localparam int QC_EN_BIT    = 0;
   localparam int QC_RXRST_BIT = 1;
   localparam int QC_TXRST_BIT = 2;
   localparam int QC_DMA_BIT   = 3;
   localparam int QC_TRIG_LO   = 6;
   // Trigger levels for codes 00..11
   localparam logic [4:0] TRIG_0 = 5'h01;
   localparam logic [4:0] TRIG_1 = 5'h04;
   localparam logic [4:0] TRIG_2 = 5'h08;
   localparam logic [4:0] TRIG_3 = 5'h0e;
   // Interrupt source codes, bits 3:0
   localparam logic [3:0] SRC_NONE = 4'h1;
   localparam logic [3:0] SRC_LS   = 4'h6;
   localparam logic [3:0] SRC_RX   = 4'h4;
   localparam logic [3:0] SRC_TO   = 4'hc;
   localparam logic [3:0] SRC_TX   = 4'h2;
   localparam logic [3:0] SRC_MS   = 4'h0;
   localparam logic [1:0] SRC_FIFO_ON = 2'h3;
   // Line status reset value
   localparam logic [7:0] LSR_RESET = 8'h60;
   // Baud oversampling
   localparam logic [3:0] OVS_LAST  = 4'hf;
   localparam logic [3:0] OVS_HALF  = 4'h7;
   localparam int         DATA_BITS = 8;
   localparam logic [3:0] BITS_LAST = 4'h7;
   // Timeout length: four characters of ten bits, in 16x ticks
   localparam int         TIMEOUT_TICKS = 4 * 10 * 16;
   // Default baud divisor of the 16x tick
   localparam int         DIV_DEFAULT = 1;
endpackage : uart_chan_pkg

// ### logic/byte_fifo.sv
// Synchronous FIFO used for both transmit and receive queues.
// Assumes a single clock; flush empties it, shifter state is elsewhere.
`timescale 1ns/1ps
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16,
   parameter int AW    = 4
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Control
   input  wire logic             flush,
   input  wire logic             push,
   input  wire logic [WIDTH-1:0] push_data,
   input  wire logic             pop,
   // Status
   output logic      [WIDTH-1:0] head_data,
   output logic      [AW:0]      fill
);
   logic [WIDTH-1:0] mem [DEPTH];    // Storage
   logic [AW-1:0]    wr_reg;         // Write pointer
   logic [AW-1:0]    rd_reg;         // Read pointer
   logic [AW:0]      cnt_reg;        // Entries held
   wire              do_push = push && (cnt_reg != (AW+1)'(DEPTH));
   wire              do_pop  = pop && (cnt_reg != '0);

   assign head_data = mem[rd_reg];
   assign fill      = cnt_reg;

   // Pointers and count; flush wins over traffic
   always_ff @(posedge clk) begin
      if (!rst_n || flush) begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         if (do_push) wr_reg <= wr_reg + 1'b1;
         if (do_pop)  rd_reg <= rd_reg + 1'b1;
         cnt_reg <= cnt_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end

   // Data array, no reset needed
   always_ff @(posedge clk) begin
      if (do_push) mem[wr_reg] <= push_data;
   end
endmodule : byte_fifo

// ### logic/rx_start_check.sv
// Start-bit qualifier and character assembler on the 16x tick.
// Assumes rx_line is already synchronised to clk.
`timescale 1ns/1ps
module rx_start_check
   import uart_chan_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Line side
   input  wire logic       tick16,
   input  wire logic       rx_line,
   // Character out
   output logic            char_valid,
   output logic [7:0]      char_data,
   output logic            char_frame_err,
   output logic            char_break
);
   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b10,
      RX_STOP  = 2'b11
   } rx_state_t;

   rx_state_t  state_reg;       // Receiver state
   logic [3:0] ovs_reg;         // 16x phase count
   logic [3:0] bit_reg;         // Data bit index
   logic [7:0] shift_reg;       // receive_shifter contents
   logic       prev_reg;        // Line one tick ago, for edge find
   wire        fall = prev_reg && !rx_line;

   // Assembler; after start check, sample each 16 ticks mid-bit
   always_ff @(posedge clk) begin
      char_valid <= 1'b0;
      if (!rst_n) begin
         state_reg      <= RX_IDLE;
         ovs_reg        <= '0;
         bit_reg        <= '0;
         shift_reg      <= '0;
         prev_reg       <= 1'b1;
         char_data      <= '0;
         char_frame_err <= 1'b0;
         char_break     <= 1'b0;
      end else if (tick16) begin
         prev_reg <= rx_line;
         ovs_reg  <= ovs_reg + 1'b1;
         unique case (state_reg)
            RX_IDLE: if (fall) begin
               ovs_reg   <= '0;       // Count starts on falling edge RQ2
               state_reg <= RX_START;
            end
            RX_START: if (ovs_reg == OVS_HALF) begin
               ovs_reg   <= '0;
               // Still low mid-bit: valid, else false start RQ2
               state_reg <= rx_line ? RX_IDLE : RX_DATA;
               bit_reg   <= '0;
            end
            RX_DATA: if (ovs_reg == OVS_LAST) begin
               shift_reg <= {rx_line, shift_reg[7:1]};
               bit_reg   <= bit_reg + 1'b1;
               if (bit_reg == BITS_LAST) state_reg <= RX_STOP;
            end
            RX_STOP: if (ovs_reg == OVS_LAST) begin
               state_reg      <= RX_IDLE;
               char_valid     <= 1'b1;
               char_data      <= shift_reg;
               char_frame_err <= !rx_line;
               char_break     <= !rx_line && (shift_reg == '0);
            end
         endcase
      end
   end
endmodule : rx_start_check

// ### logic/uart_channel.sv
// One serial channel: host registers, FIFOs, interrupts, DMA pins.
// Assumes a host strobing rd/wr for one clock per access.
// Function
// RQ1: Holding write stores data; empty flag tracks
// RQ2: Start edge, 7.5 ticks, still low validates
// RQ3: Receive interrupt at trigger, drops below it
// RQ4: Source status shows trigger, clears below
// RQ5: Data ready set on push, clear empty
// RQ6: FIFOs on, mask zero: polled status
// RQ7: Line status bits report errors, empties
// RQ8: Mask bit 0 gates receive interrupt
// RQ9: Mask bit 1 gates transmit empty
// RQ10: Mask bit 2 gates line status
// RQ11: Mask bit 3 gates modem status
// RQ12: Power down bit held zero here
// RQ13: Unused mask and queue bits read zero
// RQ14: Queue writes need bit 0 set
// RQ15: Bit 1 flushes receive queue, self-clears
// RQ16: Bit 2 flushes transmit queue, self-clears
// RQ17: Bit 3 selects DMA mode
// RQ18: Mode 0 tx ready low when empty
// RQ19: Mode 0 rx ready low holding data
// RQ20: Mode 1 tx ready high only full
// RQ21: Mode 1 rx ready: trigger/timeout to empty
// RQ22: Trigger codes give 1,4,8,14
// RQ23: Source read reports and clears highest
// RQ24: Overrun sets flag, char discarded
// RQ25: Sixteen-deep FIFOs with error flags
// RQ26: Timeout after four idle characters
`timescale 1ns/1ps
module uart_channel
   import uart_chan_pkg::*;
#(
   parameter int DEPTH   = 16,
   parameter int DIVISOR = DIV_DEFAULT
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Host register bus
   input  wire logic [2:0] addr,
   input  wire logic       rd,
   input  wire logic       wr,
   input  wire logic [7:0] host_data_bus,
   output logic      [7:0] rd_data,
   // Serial line
   input  wire logic       rx_line,
   output logic            tx_line,
   // Modem status event from outside, same clock
   input  wire logic       modem_event,
   // Pins
   output logic            irq,
   output logic            tx_ready_n,
   output logic            rx_ready_n
);
   localparam int AW = $clog2(DEPTH);

   // Register state
   logic [7:0]  mask_reg;         // interrupt_mask
   logic        fifo_en_reg;      // Queue enable
   logic        dma_mode_reg;     // DMA mode select
   logic [1:0]  trig_code_reg;    // Trigger code
   logic        overrun_reg;      // Sticky overrun
   logic        ls_pend_reg;      // Line status event pending
   logic        tx_pend_reg;      // Transmit empty event pending
   logic        ms_pend_reg;      // Modem event pending
   logic        rx_dma_reg;       // Mode 1 rx ready latch
   logic [7:0]  line_ctl_reg;     // Spare line control storage
   logic [10:0] to_cnt_reg;       // Timeout tick count
   logic        timeout_reg;      // Timeout seen
   logic [15:0] div_reg;          // 16x tick divider
   logic        tick16;           // 16x tick
   logic        rx_s1_reg;        // Line sync stage 1
   logic        rx_s2_reg;        // Line sync stage 2
   logic        modem_prev_reg;   // Edge detect of modem input

   // Transmit shifter state
   logic [9:0]  tx_shift_reg;     // transmit_shifter
   logic [3:0]  tx_bits_reg;      // Bits left
   logic [3:0]  tx_ovs_reg;       // 16x phase
   logic        tx_busy_reg;      // Shifter active

   // Receive side signals
   logic        rc_valid;
   logic [7:0]  rc_data;
   logic        rc_ferr;
   logic        rc_brk;
   logic [9:0]  rx_head;          // Data plus frame, break flags
   logic [AW:0] rx_fill;
   logic [7:0]  tx_head;
   logic [AW:0] tx_fill;

   // Decode of host access
   wire sel_hold  = addr == ADDR_HOLDING;
   wire sel_mask  = addr == ADDR_MASK;
   wire sel_queue = addr == ADDR_QUEUE;
   wire sel_lctl  = addr == ADDR_LINE_CTL;
   wire sel_lstat = addr == ADDR_LINE_STAT;
   wire wr_hold   = wr && sel_hold;
   wire rd_hold   = rd && sel_hold;
   wire rd_src    = rd && sel_queue;
   wire rd_lstat  = rd && sel_lstat;

   // Queue write only counts with bit 0 set RQ14
   wire wr_queue  = wr && sel_queue && host_data_bus[QC_EN_BIT];
   wire fifo_off_wr = wr && sel_queue && !host_data_bus[QC_EN_BIT];

   // Flush pulses; bits are never stored, so they self-clear RQ15 RQ16
   wire rx_flush  = wr_queue && host_data_bus[QC_RXRST_BIT];
   wire tx_flush  = wr_queue && host_data_bus[QC_TXRST_BIT];

   // Depth: 16 without FIFOs collapses to one holding place
   wire [AW:0] cap = fifo_en_reg ? (AW+1)'(DEPTH) : (AW+1)'(1);
   wire rx_full   = rx_fill >= cap;
   wire tx_full   = tx_fill >= cap;
   wire rx_empty  = rx_fill == '0;
   wire tx_empty  = tx_fill == '0;

   // Overrun: full queue drops the character RQ24
   wire rx_push   = rc_valid && !rx_full;
   wire rx_ovf    = rc_valid && rx_full;
   wire tx_push   = wr_hold && !tx_full;                      // RQ1
   wire tx_load   = !tx_busy_reg && !tx_empty;
   // Arming the empty event RQ9
   wire tx_arm    = wr && sel_mask && host_data_bus[MASK_TX_BIT] && tx_empty;

   // Trigger level decode RQ22
   wire [4:0] trig_lvl = (trig_code_reg == 2'b00) ? TRIG_0 :
                         (trig_code_reg == 2'b01) ? TRIG_1 :
                         (trig_code_reg == 2'b10) ? TRIG_2 : TRIG_3;

   wire rx_at_trig = fifo_en_reg ? ({1'b0, rx_fill} >= trig_lvl)
                                 : !rx_empty;

   // Receive data interrupt follows fill level RQ3 RQ8
   wire int_rx = mask_reg[MASK_RX_BIT] && (rx_at_trig || timeout_reg);
   wire int_ls = mask_reg[MASK_LS_BIT] && ls_pend_reg;        // RQ10
   wire int_tx = mask_reg[MASK_TX_BIT] && tx_pend_reg;        // RQ9
   wire int_ms = mask_reg[MASK_MS_BIT] && ms_pend_reg;        // RQ11

   // Priority encoder for source status RQ23 RQ4
   wire [3:0] src_code = int_ls ? SRC_LS :
                         int_rx ? (rx_at_trig ? SRC_RX : SRC_TO) :
                         int_tx ? SRC_TX :
                         int_ms ? SRC_MS : SRC_NONE;

   wire [7:0] src_byte = {fifo_en_reg ? SRC_FIFO_ON : 2'b00, 2'b00,
                          src_code};

   // Error flags of the head character, either one sets bit 7 with FIFOs on
   logic err_any;
   assign err_any = fifo_en_reg && !rx_empty && (rx_head[8] || rx_head[9]);

   // Line status assembly; polled mode reads these RQ6 RQ7 RQ5
   wire [7:0] lstat = {err_any,
                       tx_empty && !tx_busy_reg,
                       tx_empty,
                       !rx_empty && rx_head[9],
                       !rx_empty && rx_head[8],
                       1'b0,
                       overrun_reg,
                       !rx_empty};

   // Read mux; unused mask bits stay 0 RQ13 RQ12
   wire [7:0] rd_mux = sel_hold  ? rx_head[7:0] :
                       sel_mask  ? mask_reg :
                       sel_queue ? src_byte :
                       sel_lctl  ? line_ctl_reg :
                       sel_lstat ? lstat : 8'h00;

   // Receive queue carries frame and break flags RQ25
   byte_fifo #(.WIDTH(10), .DEPTH(DEPTH), .AW(AW)) u_rx_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .flush     (rx_flush || fifo_off_wr),                   // RQ15
      .push      (rx_push),                                   // RQ5
      .push_data ({rc_brk, rc_ferr, rc_data}),
      .pop       (rd_hold),
      .head_data (rx_head),
      .fill      (rx_fill)
   );

   // Transmit queue
   byte_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) u_tx_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .flush     (tx_flush || fifo_off_wr),                   // RQ16
      .push      (tx_push),
      .push_data (host_data_bus),
      .pop       (tx_load),
      .head_data (tx_head),
      .fill      (tx_fill)
   );

   // Start-bit check and assembly
   rx_start_check u_rx (
      .clk            (clk),
      .rst_n          (rst_n),
      .tick16         (tick16),
      .rx_line        (rx_s2_reg),                            // RQ2
      .char_valid     (rc_valid),
      .char_data      (rc_data),
      .char_frame_err (rc_ferr),
      .char_break     (rc_brk)
   );

   // Two-stage synchroniser on the line pin
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rx_s1_reg <= 1'b1;
         rx_s2_reg <= 1'b1;
      end else begin
         rx_s1_reg <= rx_line;
         rx_s2_reg <= rx_s1_reg;
      end
   end

   // 16x tick divider; fixed rate since the divisor latch is elsewhere
   always_ff @(posedge clk) begin
      if (!rst_n || div_reg == 16'(DIVISOR - 1)) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + 1'b1;
      end
   end

   assign tick16 = (div_reg == 16'(DIVISOR - 1));

   // Host writes to control registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mask_reg      <= '0;
         fifo_en_reg   <= 1'b0;
         dma_mode_reg  <= 1'b0;
         trig_code_reg <= '0;
         line_ctl_reg  <= '0;
      end else begin
         if (wr && sel_mask)
            mask_reg <= host_data_bus & MASK_USED;           // RQ12 RQ13
         if (wr && sel_lctl) line_ctl_reg <= host_data_bus;
         if (fifo_off_wr) fifo_en_reg <= 1'b0;
         if (wr_queue) begin                                  // RQ14
            fifo_en_reg   <= 1'b1;
            dma_mode_reg  <= host_data_bus[QC_DMA_BIT];       // RQ17
            trig_code_reg <= host_data_bus[QC_TRIG_LO +: 2];  // RQ22
         end
      end
   end

   // Sticky event flags; a new event wins over the read that clears
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         overrun_reg    <= 1'b0;
         ls_pend_reg    <= 1'b0;
         tx_pend_reg    <= 1'b0;
         ms_pend_reg    <= 1'b0;
         modem_prev_reg <= 1'b0;
      end else begin
         modem_prev_reg <= modem_event;

         if (rx_ovf) overrun_reg <= 1'b1;                     // RQ24
         else if (rd_lstat) overrun_reg <= 1'b0;

         // Line status event on each arrival RQ10
         if (rc_valid) ls_pend_reg <= 1'b1;
         else if (rd_lstat || (rd_src && src_code == SRC_LS))
            ls_pend_reg <= 1'b0;

         // Holding empty raises, write or source read clears RQ9 RQ1
         if ((tx_load && tx_fill == (AW+1)'(1)) || tx_arm)
            tx_pend_reg <= 1'b1;
         else if (wr_hold || (rd_src && src_code == SRC_TX))
            tx_pend_reg <= 1'b0;

         if (modem_event && !modem_prev_reg) ms_pend_reg <= 1'b1;
         else if (rd_src && src_code == SRC_MS) ms_pend_reg <= 1'b0;
      end
   end

   // Receive timeout: idle ticks while data waits RQ26
   always_ff @(posedge clk) begin
      if (!rst_n || rx_empty || rc_valid || rd_hold) begin
         to_cnt_reg  <= '0;
         timeout_reg <= 1'b0;
      end else if (tick16 && !timeout_reg) begin
         to_cnt_reg <= to_cnt_reg + 1'b1;
         if (to_cnt_reg == 11'(TIMEOUT_TICKS - 1)) timeout_reg <= 1'b1;
      end
   end

   // Transmit shifter: start, 8 data, stop at 16 ticks per bit
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tx_shift_reg <= '1;
         tx_bits_reg  <= '0;
         tx_ovs_reg   <= '0;
         tx_busy_reg  <= 1'b0;
      end else if (tx_load) begin
         tx_shift_reg <= {1'b1, tx_head, 1'b0};
         tx_bits_reg  <= 4'(DATA_BITS + 1);
         tx_ovs_reg   <= '0;
         tx_busy_reg  <= 1'b1;
      end else if (tx_busy_reg && tick16) begin
         tx_ovs_reg <= tx_ovs_reg + 1'b1;
         if (tx_ovs_reg == OVS_LAST) begin
            tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
            tx_bits_reg  <= tx_bits_reg - 1'b1;
            if (tx_bits_reg == '0) tx_busy_reg <= 1'b0;
         end
      end
   end

   // Mode 1 receive ready latch: set at trigger/timeout, drop on empty
   always_ff @(posedge clk) begin
      if (!rst_n || rx_empty) begin
         rx_dma_reg <= 1'b0;
      end else if (rx_at_trig || timeout_reg) begin
         rx_dma_reg <= 1'b1;                                  // RQ21
      end
   end

   // Registered outputs
   wire mode1 = fifo_en_reg && dma_mode_reg;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rd_data    <= '0;
         tx_line    <= 1'b1;
         irq        <= 1'b0;
         tx_ready_n <= 1'b0;
         rx_ready_n <= 1'b1;
      end else begin
         rd_data <= rd_mux;
         tx_line <= tx_busy_reg ? tx_shift_reg[0] : 1'b1;
         irq     <= int_ls || int_rx || int_tx || int_ms;    // RQ3 RQ4

         // Mode 1 vs mode 0 ready pins RQ18 RQ19 RQ20 RQ21
         tx_ready_n <= mode1 ? tx_full : !tx_empty;
         rx_ready_n <= mode1 ? !rx_dma_reg : rx_empty;
      end
   end
endmodule : uart_channel

// ### sim/uart_channel_monitor.sv
// Checker for the serial channel, watching only its top-level ports.
// Assumes 1 clock and a sync active-low reset; bound below to the design.
`timescale 1ns/1ps
module uart_channel_monitor
   import uart_chan_pkg::*;
#(
   parameter int DEPTH   = 16,
   parameter int DIVISOR = DIV_DEFAULT
) (
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   // Host register bus
   input wire logic [2:0] addr,
   input wire logic       rd,
   input wire logic       wr,
   input wire logic [7:0] host_data_bus,
   input wire logic [7:0] rd_data,
   // Serial line and pins
   input wire logic       rx_line,
   input wire logic       tx_line,
   input wire logic       modem_event,
   input wire logic       irq,
   input wire logic       tx_ready_n,
   input wire logic       rx_ready_n
);
   logic [3:0]  mask_reg;      // Shadow of the enable mask
   logic        fifo_on_reg;   // Shadow of the queue enable
   logic [3:0]  drain_cnt_reg; // Clocks since a pop or queue write
   logic [11:0] tx_cnt_reg;    // Clocks since a holding write
   wire hold_wr = wr && addr == ADDR_HOLDING;
   wire drain   = !rst_n || (rd && addr == ADDR_HOLDING)
      || (wr && addr == ADDR_QUEUE);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Shadows follow host writes, so reads can be predicted
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mask_reg    <= 4'h0;
         fifo_on_reg <= 1'b0;
      end else if (wr && addr == ADDR_MASK) begin
         mask_reg    <= host_data_bus[3:0];
      end else if (wr && addr == ADDR_QUEUE) begin
         fifo_on_reg <= host_data_bus[0];
      end
   end
   // Saturating ages; fff means idle long enough to drain a full queue
   always_ff @(posedge clk) begin
      drain_cnt_reg <= drain ? 4'h0
         : drain_cnt_reg + {3'h0, drain_cnt_reg != 4'hf};
      tx_cnt_reg    <= !rst_n ? 12'hfff : hold_wr ? 12'h000
                       : tx_cnt_reg + {11'h0, tx_cnt_reg != 12'hfff};
   end

   a_reset_pins: assert property (disable iff (1'b0)
      !rst_n |=> tx_line && !irq && !tx_ready_n && rx_ready_n
         && rd_data == 8'h00)
      else $error("pins not at reset values");
   a_mask_spare: assert property (
      rd && addr == ADDR_MASK |=> rd_data[7:4] == 4'h0)
      else $error("unused mask bits read nonzero");
   a_mask_read: assert property (
      rd && addr == ADDR_MASK |=> rd_data[3:0] == $past(mask_reg))
      else $error("mask readback differs from last write");
   a_source_fifo: assert property (
      rd && addr == ADDR_QUEUE
      |=> rd_data[7:4] == {{2{$past(fifo_on_reg)}}, 2'b00})
      else $error("source status queue bits wrong");
   a_empties_order: assert property (
      rd && addr == ADDR_LINE_STAT |=> !rd_data[6] || rd_data[5])
      else $error("both-empty set while queue not empty");
   a_quiet_mask: assert property (
      mask_reg == 4'h0 && $past(mask_reg) == 4'h0 |-> !irq)
      else $error("interrupt with all enables clear");
   a_rx_rise: assert property (
      $rose(rx_ready_n) |-> drain_cnt_reg <= 4'h4)
      else $error("receive ready released without a pop");
   a_tx_start: assert property (
      hold_wr && tx_cnt_reg == 12'hfff |-> ##[1:6] !tx_line ##1 !tx_line [*7])
      else $error("no start bit after holding write");
   a_tx_idle: assert property (tx_cnt_reg == 12'hfff |-> tx_line)
      else $error("line not idle after long quiet");
endmodule : uart_channel_monitor

bind uart_channel uart_channel_monitor
   #(.DEPTH(DEPTH), .DIVISOR(DIVISOR)) u_monitor (
   .clk(clk), .rst_n(rst_n), .addr(addr), .rd(rd), .wr(wr),
   .host_data_bus(host_data_bus), .rd_data(rd_data), .rx_line(rx_line),
   .tx_line(tx_line), .modem_event(modem_event), .irq(irq),
   .tx_ready_n(tx_ready_n), .rx_ready_n(rx_ready_n));

// ### sim/line_sender.sv
// Remote serial sender feeding the channel's receive line.
// Assumes the 16x tick runs every clock, so one bit is BIT_CLKS clocks.
`timescale 1ns/1ps
module line_sender #(
   parameter int BIT_CLKS = 16 // Clocks per bit
) (
   // Clock
   input  wire logic clk,
   // Line
   output logic      rx_line
);
   initial rx_line = 1'b1; // Idle mark level between frames
   // One 8N1 frame, low bit first
   task automatic send(input logic [7:0] b);
      logic [9:0] fr;
      fr = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clk);
         #1 rx_line = fr[i];
         repeat (BIT_CLKS - 1) @(posedge clk);
      end
   endtask : send
   // Short low pulse, a false start
   task automatic glitch(input int n);
      @(posedge clk);
      #1 rx_line = 1'b0;
      repeat (n) @(posedge clk);
      #1 rx_line = 1'b1;
   endtask : glitch
endmodule : line_sender

// ### sim/uart_channel_tb.sv
// Testbench for the serial channel: register tasks and scenarios.
// Assumes DIVISOR 1, so one bit is 16 clocks; line fed by line_sender.
`timescale 1ns/1ps
module uart_channel_tb;
   import uart_chan_pkg::*;
   logic       clk = 1'b0; // 40 MHz
   logic       rst_n, rd, wr, modem_event;
   logic [2:0] addr;
   logic [7:0] host_data_bus;
   wire  [7:0] rd_data;
   wire        rx_line, tx_line, irq, tx_ready_n, rx_ready_n;
   int         fails = 0;
   int         samples_checked = 0;

   always #12.5 clk = ~clk;

   uart_channel u_dut (
      .clk(clk), .rst_n(rst_n), .addr(addr), .rd(rd), .wr(wr),
      .host_data_bus(host_data_bus), .rd_data(rd_data), .rx_line(rx_line),
      .tx_line(tx_line), .modem_event(modem_event), .irq(irq),
      .tx_ready_n(tx_ready_n), .rx_ready_n(rx_ready_n));
   line_sender u_line (.clk(clk), .rx_line(rx_line));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 addr = a;
      host_data_bus = d;
      wr = 1'b1;
      @(posedge clk);
      #1 wr = 1'b0;
   endtask : reg_wr
   // Read data lands on the edge that takes the strobe
   task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk);
      #1 addr = a;
      rd = 1'b1;
      @(posedge clk);
      #1 rd = 1'b0;
      check(rd_data, exp);
   endtask : rd_chk
   // Bounded wait for the receive ready pin
   task automatic wait_rx(input logic lvl, input int lim);
      for (int n = 0; n < lim && rx_ready_n !== lvl; n++)
         @(posedge clk) #1;
      check({7'h00, rx_ready_n}, {7'h00, lvl});
   endtask : wait_rx
   task automatic finish_test;
      if (fails == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : finish_test

   task automatic t_reset;
      check({7'h00, tx_ready_n}, 8'h00);
      rd_chk(ADDR_MASK, 8'h00);
      rd_chk(ADDR_QUEUE, 8'h01);
      rd_chk(ADDR_LINE_STAT, 8'h60);
      reg_wr(ADDR_MASK, 8'hf0);
      rd_chk(ADDR_MASK, 8'h00);
   endtask : t_reset
   // Transmit empty outranks modem status; each read clears one
   task automatic t_irq_order;
      reg_wr(ADDR_MASK, 8'h0a);
      #1 modem_event = 1'b1;
      repeat (3) @(posedge clk);
      #1 check({7'h00, irq}, 8'h01);
      rd_chk(ADDR_QUEUE, 8'h02);
      rd_chk(ADDR_QUEUE, 8'h00);
      rd_chk(ADDR_QUEUE, 8'h01);
      repeat (2) @(posedge clk);
      #1 check({7'h00, irq}, 8'h00);
      reg_wr(ADDR_MASK, 8'h00);
   endtask : t_irq_order
   task automatic t_rx_mode0;
      reg_wr(ADDR_QUEUE, 8'h01);
      u_line.glitch(4);
      repeat (16) @(posedge clk);
      wait_rx(1'b1, 60);
      u_line.send(8'ha5);
      wait_rx(1'b0, 40);
      rd_chk(ADDR_LINE_STAT, 8'h61);
      rd_chk(ADDR_HOLDING, 8'ha5);
      wait_rx(1'b1, 8);
      rd_chk(ADDR_LINE_STAT, 8'h60);
   endtask : t_rx_mode0
   // Each trigger code: quiet one short of level, raised at it
   task automatic t_trigger;
      logic [4:0] lv [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
      reg_wr(ADDR_MASK, 8'h01);
      for (int c = 0; c < 4; c++) begin
         reg_wr(ADDR_QUEUE, {c[1:0], 6'h03});
         repeat (lv[c] - 1) u_line.send(8'h11);
         repeat (4) @(posedge clk);
         #1 check({7'h00, irq}, 8'h00);
         u_line.send(8'h22);
         repeat (4) @(posedge clk);
         #1 check({7'h00, irq}, 8'h01);
         rd_chk(ADDR_QUEUE, 8'hc4);
         reg_wr(ADDR_QUEUE, {c[1:0], 6'h03});
         repeat (3) @(posedge clk);
         #1 check({7'h00, irq}, 8'h00);
         rd_chk(ADDR_LINE_STAT, 8'h60);
      end
      reg_wr(ADDR_MASK, 8'h00);
   endtask : t_trigger
   // Block mode: one char under level 4 waits for the timeout
   task automatic t_mode1_rx;
      reg_wr(ADDR_QUEUE, 8'h4b);
      u_line.send(8'h3c);
      repeat (4) @(posedge clk);
      #1 check({7'h00, rx_ready_n}, 8'h01);
      wait_rx(1'b0, 800);
      rd_chk(ADDR_HOLDING, 8'h3c);
      wait_rx(1'b1, 8);
   endtask : t_mode1_rx
   // Fill the queue behind a busy shifter, then flush it
   task automatic t_mode1_tx;
      reg_wr(ADDR_QUEUE, 8'h09);
      for (int i = 0; i < 17; i++) reg_wr(ADDR_HOLDING, i[7:0]);
      repeat (2) @(posedge clk);
      #1 check({7'h00, tx_ready_n}, 8'h01);
      rd_chk(ADDR_LINE_STAT, 8'h00);
      reg_wr(ADDR_QUEUE, 8'h0d);
      repeat (2) @(posedge clk);
      #1 check({7'h00, tx_ready_n}, 8'h00);
      rd_chk(ADDR_LINE_STAT, 8'h20);
   endtask : t_mode1_tx

   initial begin
      rst_n = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      addr = 3'h0;
      host_data_bus = 8'h00;
      modem_event = 1'b0;
      repeat (5) @(posedge clk);
      #1 rst_n = 1'b1;
      t_reset();
      t_irq_order();
      t_rx_mode0();
      t_trigger();
      t_mode1_rx();
      t_mode1_tx();
      finish_test();
   end
   // Watchdog, about seven times the expected run
   initial begin
      repeat (40000) @(posedge clk);
      fails++;
      finish_test();
   end
endmodule : uart_channel_tb
